//--- rtl/cycle_timer.sv
`timescale 1ns/100ps
module cycle_timer
  import hub_seq_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // control
  input wire logic start,
  input wire logic stop,
  input wire logic [TIMER_W-1:0] limit,
  // status
  output logic [TIMER_W-1:0] count,
  output logic busy,
  output logic expired
);

  // ---------------------------------------------------------------
  // count up from start; pulse expired limit edges after start
  // ---------------------------------------------------------------
  wire at_limit = (count == limit - TIMER_W'(1));  // last counted cycle

  // start outranks stop so a restart is never lost
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      count <= '0;
      busy <= 1'b0;
      expired <= 1'b0;
    end else if (start) begin
      count <= '0;
      busy <= 1'b1;
      expired <= 1'b0;
    end else if (stop || !busy) begin
      busy <= 1'b0;
      expired <= 1'b0;
    end else if (at_limit) begin
      busy <= 1'b0;
      expired <= 1'b1;
    end else begin
      count <= count + TIMER_W'(1);
      expired <= 1'b0;
    end
  end

endmodule

//--- rtl/hub_reset_attach_sequencer.sv
`timescale 1ns/100ps
// Summary of operation
// R1: board holds reset low at least 1 us
// R2: strap mode outputs inactive within 2 us
// R3: sample led straps after reset release
// R4: eeprom: recover 500 us, load within 99.5 ms
// R5: smbus code load limit is 300 ms
// R6: bus powered smbus load within 99.5 ms
// R7: self powered smbus load waits indefinitely
// R8: smbus: attach within 100 ms of load
// R9: strap/eeprom: attach within 100 ms of config
// R10: host waits 100 ms before bus reset
// R11: each standard request completes within 5 ms
// R12: bus reset never forwarded downstream
// R13: bus reset clears device address
// R14: bus reset returns to unconfigured
// R15: bus reset drops downstream port power 7:1
// R16: bus reset empties translator buffers
// R17: bus reset wakes a suspended hub
// R18: one sequencer, path chosen by select straps
module hub_reset_attach_sequencer
  import hub_seq_pkg::*;
#(
  parameter int RECOVERY_CYC = RECOVER_MAX_CYC,
  parameter int EE_LIMIT_CYC = EE_LOAD_MAX_CYC,
  parameter int SMB_LATE_CYC = SMB_LOAD_MAX_CYC,
  parameter int SMB_BUSPWR_CYC = SMB_BUSPWR_MAX_CYC,
  parameter int REQ_LIMIT_CYC = REQ_MAX_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // configuration straps
  input wire logic config_source_select_hi,
  input wire logic config_source_select_lo,
  input wire logic self_powered,
  input wire logic [7:1] led_amber_in,
  input wire logic [7:1] led_green_in,
  // indicator pins
  output logic [7:1] led_amber_out,
  output logic led_amber_oe_n,
  output logic [7:1] led_green_out,
  output logic led_green_oe_n,
  // configuration load
  input wire logic eeprom_load_done,
  input wire logic smbus_load_done,
  output logic eeprom_read_en,
  output logic smbus_slave_en,
  output logic config_load_timeout,
  output logic smbus_load_late,
  output logic use_strap_config,
  output logic [7:1] strap_amber,
  output logic [7:1] strap_green,
  // upstream port
  input wire logic usb_bus_reset,
  output logic usb_attach,
  // hub core requests
  input wire logic set_address_valid,
  input wire logic [6:0] set_address_value,
  input wire logic set_config_valid,
  input wire logic set_config_value,
  input wire logic suspend_req,
  input wire logic resume_req,
  input wire logic [7:1] port_power_on,
  input wire logic [7:1] port_power_off,
  input wire logic [7:1] port_reset_req,
  input wire logic request_start,
  input wire logic request_done,
  // hub state
  output logic [6:0] device_address,
  output logic configured,
  output logic suspended,
  output logic [7:1] downstream_port_power_en,
  output logic [7:1] downstream_port_reset,
  output logic tt_flush,
  output logic request_complete,
  output logic request_timeout
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  seq_state_type state;                 // sequencer state
  seq_state_type next_state;            // its next value
  logic [BOOT_W-1:0] boot_cnt;          // steps since release
  logic [AGE_W-1:0] boot_age;           // saturating age, checks only
  logic [1:0] source;                   // latched select straps
  logic straps_valid;                   // straps have been taken
  logic [TIMER_W-1:0] phase_count;      // recovery / load elapsed
  logic phase_busy;                     // phase timer running
  logic phase_exp;                      // phase timer expired pulse
  logic req_busy;                       // request outstanding
  logic req_exp;                        // request deadline pulse
  logic [TIMER_W-1:0] phase_limit;      // limit for the current phase

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire strap_sample = (boot_cnt == BOOT_W'(STRAP_SAMPLE_CYC - 1));
  wire boot_start = (boot_cnt == BOOT_W'(STRAP_SAMPLE_CYC));
  wire src_strap = (source == SEL_STRAP);
  wire src_smbus = source[1];
  wire in_recover = (state == ST_RECOVER);
  wire in_load = (state == ST_LOAD);
  wire in_session = (state == ST_WAIT_RESET) || (state == ST_RUN);
  wire recover_done = in_recover && phase_exp;
  wire smb_waits = src_smbus && self_powered;       // no upper limit
  wire load_ok = src_smbus ? smbus_load_done : eeprom_load_done;
  wire load_expired = phase_exp && !smb_waits;
  wire load_finish = in_load && (load_ok || load_expired);
  wire bus_reset_hit = in_session && usb_bus_reset;
  wire req_take = request_start && (state == ST_RUN) && !req_busy;
  wire req_stop = request_done || bus_reset_hit;

  // recovery limit trimmed by the strap steps already spent, except in strap mode where it is OUT_TYP_CYC
  wire [TIMER_W-1:0] recover_limit = src_strap ? TIMER_W'(OUT_TYP_CYC)
                                   : TIMER_W'(RECOVERY_CYC - BOOT_LEAD);
  // load limit: bus powered smbus is tight, self powered only flags late
  wire [TIMER_W-1:0] smb_limit = self_powered ? TIMER_W'(SMB_LATE_CYC)
                               : TIMER_W'(SMB_BUSPWR_CYC - 1);
  wire [TIMER_W-1:0] load_limit = src_smbus ? smb_limit
                                : TIMER_W'(EE_LIMIT_CYC - 1);

  assign phase_limit = in_recover ? recover_limit : load_limit;

  // ---------------------------------------------------------------
  // post-release steps: strap sample, then start of recovery
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      boot_cnt <= '0;
    end else if (boot_cnt <= BOOT_W'(STRAP_SAMPLE_CYC)) begin
      boot_cnt <= boot_cnt + BOOT_W'(1);
    end
  end

  // age since release, kept only for the output timing check
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      boot_age <= '0;
    end else if (boot_age != '1) begin
      boot_age <= boot_age + AGE_W'(1);
    end
  end

  // ---------------------------------------------------------------
  // strap latch and timers
  // ---------------------------------------------------------------
  // straps sampled inside the hold window after release
  strap_capture u_straps (  // R3
    .core_clk(core_clk),
    .rstn(rstn),
    .sample(strap_sample),
    .amber_pin(led_amber_in),
    .green_pin(led_green_in),
    .sel_hi(config_source_select_hi),
    .sel_lo(config_source_select_lo),
    .amber(strap_amber),
    .green(strap_green),
    .source(source),
    .valid(straps_valid)
  );

  // one timer covers recovery and then the load phase
  cycle_timer u_phase (
    .core_clk(core_clk),
    .rstn(rstn),
    .start(boot_start || (recover_done && !src_strap)),
    .stop(load_finish),
    .limit(phase_limit),
    .count(phase_count),
    .busy(phase_busy),
    .expired(phase_exp)
  );

  // request deadline watchdog
  cycle_timer u_request (
    .core_clk(core_clk),
    .rstn(rstn),
    .start(req_take),
    .stop(req_stop),
    .limit(TIMER_W'(REQ_LIMIT_CYC - 1)),
    .count(),
    .busy(req_busy),
    .expired(req_exp)
  );

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_RECOVER: begin
        // strap mode has no load phase: straps are the config
        if (recover_done) begin
          next_state = src_strap ? ST_ATTACH : ST_LOAD;  // R18
        end
      end
      ST_LOAD: begin
        if (load_finish) begin
          next_state = ST_ATTACH;  // R4 R7
        end
      end
      ST_ATTACH: begin
        next_state = ST_WAIT_RESET;
      end
      ST_WAIT_RESET: begin
        if (usb_bus_reset) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        next_state = ST_RUN;
      end
      default: begin
        next_state = ST_RECOVER;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_RECOVER;
    end else begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // load and attach outputs
  // ---------------------------------------------------------------
  // attach stays up across bus resets; only hardware reset drops it
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      usb_attach <= 1'b0;
      eeprom_read_en <= 1'b0;
      smbus_slave_en <= 1'b0;
      config_load_timeout <= 1'b0;
      smbus_load_late <= 1'b0;
      use_strap_config <= 1'b0;
    end else begin
      usb_attach <= usb_attach || (state == ST_ATTACH);  // R8 R9
      eeprom_read_en <= (next_state == ST_LOAD) && !src_smbus;
      smbus_slave_en <= (next_state == ST_LOAD) && src_smbus;
      // a load that runs out its limit, other than self powered smbus, raises config_load_timeout
      config_load_timeout <= config_load_timeout
                             || (in_load && load_expired && !load_ok);  // R4 R6
      smbus_load_late <= smbus_load_late
                         || (in_load && smb_waits && phase_exp);  // R5
      use_strap_config <= straps_valid && src_strap;  // R3
    end
  end

  // ---------------------------------------------------------------
  // indicator pins: released until recovery ends, then driven idle
  // ---------------------------------------------------------------
  // a strap-high pin signals active low, so its idle level is high
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      led_amber_oe_n <= 1'b1;
      led_green_oe_n <= 1'b1;
      led_amber_out <= 7'h00;
      led_green_out <= 7'h00;
    end else if (recover_done) begin
      led_amber_oe_n <= 1'b0;  // R2
      led_green_oe_n <= 1'b0;  // R2
      led_amber_out <= strap_amber;
      led_green_out <= strap_green;
    end
  end

  // ---------------------------------------------------------------
  // device state and bus reset response
  // ---------------------------------------------------------------
  // bus reset outranks every address, config, suspend and power request in the same cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      device_address <= ADDR_RESET;
      configured <= 1'b0;
      suspended <= 1'b0;
      downstream_port_power_en <= PORTS_OFF;
      tt_flush <= 1'b0;
    end else if (bus_reset_hit) begin
      device_address <= ADDR_RESET;  // R13
      configured <= 1'b0;  // R14
      suspended <= 1'b0;  // R17
      downstream_port_power_en <= PORTS_OFF;  // R15
      tt_flush <= 1'b1;  // R16
    end else begin
      tt_flush <= 1'b0;
      if (set_address_valid) begin
        device_address <= set_address_value;
      end
      if (set_config_valid) begin
        configured <= set_config_value;
      end
      // a suspend request in the same cycle as resume wins
      suspended <= suspend_req || (suspended && !resume_req);
      downstream_port_power_en <= port_power_on
                                  | (downstream_port_power_en & ~port_power_off);
    end
  end

  // downstream resets follow the core only, never the upstream reset
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      downstream_port_reset <= PORTS_OFF;
    end else begin
      downstream_port_reset <= port_reset_req;  // R12
    end
  end

  // ---------------------------------------------------------------
  // request completion: real answer or forced at the deadline
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      request_complete <= 1'b0;
      request_timeout <= 1'b0;
    end else begin
      request_complete <= (req_busy && request_done && !bus_reset_hit) || req_exp;  // R11
      request_timeout <= req_exp;  // R11
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_outputs_inactive_time: assert property (  // R2
    @(posedge core_clk) disable iff (!rstn)
    (use_strap_config && boot_age == AGE_W'(OUT_MAX_CYC)) |-> !led_amber_oe_n
  ) else $error("strap mode outputs not driven idle in time");

  chk_strap_sample_taken: assert property (  // R3
    @(posedge core_clk) disable iff (!rstn)
    (strap_sample && !straps_valid) |=> (strap_green == $past(led_green_in))
  ) else $error("green strap not captured");

  chk_recovery_bound: assert property (  // R4
    @(posedge core_clk) disable iff (!rstn)
    (in_recover && !src_strap) |-> (phase_count < TIMER_W'(RECOVERY_CYC))
  ) else $error("recovery overran its limit");

  chk_eeprom_load_bound: assert property (  // R4
    @(posedge core_clk) disable iff (!rstn)
    (in_load && !src_smbus) |-> (phase_count < TIMER_W'(EE_LIMIT_CYC))
  ) else $error("eeprom load overran its limit");

  chk_smbus_late_flag: assert property (  // R5
    @(posedge core_clk) disable iff (!rstn)
    $rose(smbus_load_late) |-> ($past(phase_count) == TIMER_W'(SMB_LATE_CYC - 1))
  ) else $error("late smbus flag at wrong time");

  chk_smbus_self_wait: assert property (  // R7
    @(posedge core_clk) disable iff (!rstn)
    (in_load && smb_waits && !smbus_load_done) |=> (state == ST_LOAD)
  ) else $error("self powered load left before done");

  chk_attach_after_load: assert property (  // R8
    @(posedge core_clk) disable iff (!rstn)
    load_finish |-> ##2 usb_attach
  ) else $error("attach not raised after config load");

  chk_bus_reset_effects: assert property (  // R13
    @(posedge core_clk) disable iff (!rstn)
    bus_reset_hit |=> (device_address == ADDR_RESET && !configured && !suspended
                       && downstream_port_power_en == PORTS_OFF && tt_flush)
  ) else $error("bus reset effects missing");

  chk_no_reset_forward: assert property (  // R12
    @(posedge core_clk) disable iff (!rstn)
    bus_reset_hit |=> (downstream_port_reset == $past(port_reset_req))
  ) else $error("bus reset reached downstream ports");

  chk_request_deadline: assert property (  // R11
    @(posedge core_clk) disable iff (!rstn)
    req_exp |=> (request_complete && request_timeout)
  ) else $error("request deadline not answered");

  chk_state_onehot: assert property (  // R18
    @(posedge core_clk) disable iff (!rstn)
    $onehot(state) && (!phase_busy || in_recover || in_load || phase_exp)
  ) else $error("sequencer state not one-hot");

endmodule

//--- rtl/hub_seq_pkg.sv
package hub_seq_pkg;

  // ---------------------------------------------------------------
  // clock and printed times
  // ---------------------------------------------------------------
  localparam real CLK_MHZ = 200.0;            // core_clk rate
  localparam real T_STRAP_HOLD_NS = 16.7;     // least strap hold after release
  localparam real T_OUT_TYP_US = 1.5;         // outputs inactive, typical
  localparam real T_OUT_MAX_US = 2.0;         // outputs inactive, longest
  localparam real T_RECOVER_MAX_US = 500.0;   // recovery after release
  localparam real T_EE_LOAD_MAX_MS = 99.5;    // eeprom read and config
  localparam real T_SMB_LOAD_MAX_MS = 300.0;  // smbus code load limit
  localparam real T_SMB_BUSPWR_MAX_MS = 99.5; // smbus load when bus powered
  localparam real T_ATTACH_MAX_MS = 100.0;    // config end to attach
  localparam real T_REQ_MAX_MS = 5.0;         // standard request completion

  // ---------------------------------------------------------------
  // cycle counts, longest times rounded down
  // ---------------------------------------------------------------
  localparam int STRAP_SAMPLE_CYC = int'($floor(T_STRAP_HOLD_NS * CLK_MHZ / 1000.0));
  localparam int OUT_TYP_CYC = int'($floor(T_OUT_TYP_US * CLK_MHZ));
  localparam int OUT_MAX_CYC = int'($floor(T_OUT_MAX_US * CLK_MHZ));
  localparam int RECOVER_MAX_CYC = int'($floor(T_RECOVER_MAX_US * CLK_MHZ));
  localparam int EE_LOAD_MAX_CYC = int'($floor(T_EE_LOAD_MAX_MS * CLK_MHZ * 1000.0));
  localparam int SMB_LOAD_MAX_CYC = int'($floor(T_SMB_LOAD_MAX_MS * CLK_MHZ * 1000.0));
  localparam int SMB_BUSPWR_MAX_CYC = int'($floor(T_SMB_BUSPWR_MAX_MS * CLK_MHZ * 1000.0));
  localparam int ATTACH_MAX_CYC = int'($floor(T_ATTACH_MAX_MS * CLK_MHZ * 1000.0));
  localparam int REQ_MAX_CYC = int'($floor(T_REQ_MAX_MS * CLK_MHZ * 1000.0));

  // ---------------------------------------------------------------
  // widths, encodings and reset values
  // ---------------------------------------------------------------
  localparam int TIMER_W = 26;                // holds the 300 ms count
  localparam int BOOT_W = 3;                  // post-release step counter
  localparam int AGE_W = 9;                   // holds the 2 us check count
  localparam int BOOT_LEAD = STRAP_SAMPLE_CYC + 2; // cycles spent before timing
  localparam logic [1:0] SEL_STRAP = 2'h0;    // default / strap config
  localparam logic [1:0] SEL_EEPROM = 2'h1;   // serial eeprom load
  localparam logic [6:0] ADDR_RESET = 7'h00;  // default device address
  localparam logic [7:1] PORTS_OFF = 7'h00;   // all downstream ports

  typedef enum logic [4:0] {
    ST_RECOVER    = 5'h01,
    ST_LOAD       = 5'h02,
    ST_ATTACH     = 5'h04,
    ST_WAIT_RESET = 5'h08,
    ST_RUN        = 5'h10
  } seq_state_type;

endpackage

//--- rtl/strap_capture.sv
`timescale 1ns/100ps
module strap_capture
  import hub_seq_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // sample strobe
  input wire logic sample,
  // strap pins
  input wire logic [7:1] amber_pin,
  input wire logic [7:1] green_pin,
  input wire logic sel_hi,
  input wire logic sel_lo,
  // captured levels
  output logic [7:1] amber,
  output logic [7:1] green,
  output logic [1:0] source,
  output logic valid
);

  // ---------------------------------------------------------------
  // strap latch: taken once after release, never under reset
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      amber <= 7'h00;
      green <= 7'h00;
      source <= SEL_STRAP;
      valid <= 1'b0;
    end else if (sample && !valid) begin
      amber <= amber_pin;
      green <= green_pin;
      source <= {sel_hi, sel_lo};
      valid <= 1'b1;
    end
  end

endmodule

//--- tb/hub_far_side_model.sv
`timescale 1ns/100ps
// configuration source and upstream host, seen from the hub's pins
module hub_far_side_model #(
  parameter int HOST_WAIT_CYC = 20 // scaled attach-to-reset wait
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // configuration source
  input wire logic [15:0] load_delay,
  input wire logic eeprom_read_en,
  input wire logic smbus_slave_en,
  output logic eeprom_load_done,
  output logic smbus_load_done,
  // upstream host
  input wire logic usb_attach,
  input wire logic reset_go,
  output logic usb_bus_reset
);
  logic [15:0] load_cnt; // cycles in the load phase
  logic [15:0] seen_cnt; // cycles since attach was seen
  // zero delay stands for a source that never finishes
  wire load_fin = (load_delay != 16'h0000) && (load_cnt == load_delay);
  // --------------------------------------------------
  // strobes and host reset
  // --------------------------------------------------
  assign eeprom_load_done = eeprom_read_en && load_fin;
  assign smbus_load_done = smbus_slave_en && load_fin;
  // host never resets before it has seen attach for its wait
  assign usb_bus_reset = reset_go && (seen_cnt >= HOST_WAIT_CYC);
  // phase counters
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      load_cnt <= 16'h0000;
      seen_cnt <= 16'h0000;
    end else begin
      load_cnt <= (eeprom_read_en || smbus_slave_en) ? load_cnt + 16'h0001 : 16'h0000;
      seen_cnt <= (usb_attach && seen_cnt != 16'hFFFF) ? seen_cnt + 16'h0001 : seen_cnt;
    end
  end
endmodule

//--- tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  import hub_seq_pkg::*;
  // shortened counts
  localparam int REC = 40;
  localparam int EE_LIM = 200;
  localparam int BUSPWR = 200;
  localparam int REQ_LIM = 100;
  // design and model inputs
  logic core_clk = 1'b0, rstn = 1'b0, config_source_select_hi = 1'b0;
  logic config_source_select_lo = 1'b0, self_powered = 1'b0, reset_go = 1'b0;
  logic [7:1] led_amber_in = 7'h00, led_green_in = 7'h00, port_power_on = 7'h00;
  logic [7:1] port_power_off = 7'h00, port_reset_req = 7'h00;
  logic set_address_valid = 1'b0, set_config_valid = 1'b0, set_config_value = 1'b0;
  logic [6:0] set_address_value = 7'h00;
  logic suspend_req = 1'b0, resume_req = 1'b0, request_start = 1'b0, request_done = 1'b0;
  logic [15:0] load_delay = 16'h0000;
  // design and model outputs
  logic [7:1] led_amber_out, led_green_out, strap_amber, strap_green;
  logic [7:1] downstream_port_power_en, downstream_port_reset;
  logic led_amber_oe_n, led_green_oe_n, eeprom_read_en, smbus_slave_en, config_load_timeout;
  logic smbus_load_late, use_strap_config, usb_attach, configured, suspended, tt_flush;
  logic request_complete, request_timeout, eeprom_load_done, smbus_load_done, usb_bus_reset;
  logic [6:0] device_address;
  int n_fail = 0;
  int cmp_count = 0;

  always #2.5 core_clk = ~core_clk;

  hub_reset_attach_sequencer #(.RECOVERY_CYC(REC), .EE_LIMIT_CYC(EE_LIM), .SMB_LATE_CYC(300),
    .SMB_BUSPWR_CYC(BUSPWR), .REQ_LIMIT_CYC(REQ_LIM)) hub_reset_attach_sequencer_inst (
    .core_clk, .rstn, .config_source_select_hi, .config_source_select_lo, .self_powered,
    .led_amber_in, .led_green_in, .led_amber_out, .led_amber_oe_n, .led_green_out,
    .led_green_oe_n, .eeprom_load_done, .smbus_load_done, .eeprom_read_en, .smbus_slave_en,
    .config_load_timeout, .smbus_load_late, .use_strap_config, .strap_amber, .strap_green,
    .usb_bus_reset, .usb_attach, .set_address_valid, .set_address_value, .set_config_valid,
    .set_config_value, .suspend_req, .resume_req, .port_power_on, .port_power_off,
    .port_reset_req, .request_start, .request_done, .device_address, .configured, .suspended,
    .downstream_port_power_en, .downstream_port_reset, .tt_flush, .request_complete,
    .request_timeout);

  hub_far_side_model hub_far_side_model_inst (.core_clk, .rstn, .load_delay, .eeprom_read_en,
    .smbus_slave_en, .eeprom_load_done, .smbus_load_done, .usb_attach, .reset_go,
    .usb_bus_reset);

  // --------------------------------------------------
  // helpers
  // --------------------------------------------------
  // inputs move 1 ns after the rising edge, except the first settings made at time 0
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic timed_out();
    n_fail++;
    $display("MISMATCH t=%0t wait ran out got=%h exp=%h", $time, 1'b0, 1'b1);
    wrap_up();
  endtask

  // bounded poll; n is the number of edges waited
  task automatic wait_for(input int which, input int bound, output int n);
    logic hit;
    n = 0;
    hit = 1'b0;
    while (!hit) begin
      case (which)
        0: hit = (led_amber_oe_n === 1'b0);
        1: hit = ((eeprom_read_en | smbus_slave_en) === 1'b1);
        2: hit = (usb_attach === 1'b1);
        3: hit = (usb_bus_reset === 1'b1);
        default: hit = (request_timeout === 1'b1);
      endcase
      if (!hit && n >= bound) timed_out();
      if (!hit) begin
        tick();
        n++;
      end
    end
  endtask

  task automatic hw_reset(input logic hi, lo, sp, input logic [15:0] dly);
    rstn = 1'b0;
    config_source_select_hi = hi;
    config_source_select_lo = lo;
    self_powered = sp;
    load_delay = dly;
    reset_go = 1'b0;
    repeat (16) tick();
    rstn = 1'b1;
  endtask

  // --------------------------------------------------
  // scenarios
  // --------------------------------------------------
  task automatic strap_case();
    int n;
    led_amber_in = 7'h55;
    led_green_in = 7'h2A;
    hw_reset(1'b0, 1'b0, 1'b1, 16'h0000);
    check(led_amber_oe_n, 1'b1);
    repeat (4) tick();
    // straps move after capture and must not be taken again
    led_amber_in = 7'h2A;
    led_green_in = 7'h55;
    wait_for(0, OUT_MAX_CYC - 4, n);
    check(led_green_oe_n, 1'b0);
    check(strap_amber, 7'h55);
    check(strap_green, 7'h2A);
    check(led_amber_out, 7'h55);
    check(led_green_out, 7'h2A);
    check(use_strap_config, 1'b1);
    wait_for(2, 400, n);
    check(eeprom_read_en | smbus_slave_en, 1'b0);
    $display("test strap finished");
  endtask

  // attach must land in [lo_b, hi_b] edges after the load phase opens
  task automatic load_case(input logic hi, lo, sp, input logic [15:0] dly,
                           input logic exp_to, exp_late, input int lo_b, hi_b);
    int n;
    hw_reset(hi, lo, sp, dly);
    wait_for(1, REC, n);
    check(eeprom_read_en, !hi);
    check(use_strap_config, 1'b0);
    wait_for(2, hi_b, n);
    check(32'(n >= lo_b), 32'h1);
    check(config_load_timeout, exp_to);
    check(smbus_load_late, exp_late);
    check(eeprom_read_en | smbus_slave_en, 1'b0);
    $display("test load finished");
  endtask

  task automatic bus_reset_case();
    int n;
    reset_go = 1'b1;
    wait_for(3, 40, n);
    tick();
    reset_go = 1'b0;
    tick();
    set_address_valid = 1'b1;
    set_address_value = 7'h2B;
    set_config_valid = 1'b1;
    set_config_value = 1'b1;
    port_power_on = 7'h7F;
    port_reset_req = 7'h05;
    suspend_req = 1'b1;
    resume_req = 1'b1;
    tick();
    {set_address_valid, set_config_valid, suspend_req, resume_req} = 4'h0;
    port_power_on = 7'h00;
    port_power_off = 7'h05;
    tick();
    check(device_address, 7'h2B);
    check(suspended, 1'b1);
    check(downstream_port_power_en, 7'h7A);
    reset_go = 1'b1;
    tick();
    check(device_address, ADDR_RESET);
    check(configured, 1'b0);
    check(downstream_port_power_en, PORTS_OFF);
    check(tt_flush, 1'b1);
    check(suspended, 1'b0);
    check(downstream_port_reset, 7'h05);
    check(usb_attach, 1'b1);
    reset_go = 1'b0;
    tick();
    tick();
    check(tt_flush, 1'b0);
    $display("test bus reset finished");
  endtask

  task automatic request_case();
    int n;
    request_start = 1'b1;
    tick();
    request_start = 1'b0;
    repeat (5) tick();
    request_done = 1'b1;
    tick();
    request_done = 1'b0;
    check(request_complete, 1'b1);
    check(request_timeout, 1'b0);
    tick();
    // a request the core never answers
    request_start = 1'b1;
    tick();
    request_start = 1'b0;
    wait_for(4, REQ_LIM + 4, n);
    check(32'(n >= REQ_LIM - 3), 32'h1);
    check(request_complete, 1'b1);
    $display("test request finished");
  endtask

  initial begin
    strap_case();
    load_case(1'b0, 1'b1, 1'b1, 16'h0032, 1'b0, 1'b0, 49, 58);
    load_case(1'b0, 1'b1, 1'b0, 16'h0000, 1'b1, 1'b0, EE_LIM - 8, EE_LIM + 8);
    load_case(1'b1, 1'b0, 1'b0, 16'h003C, 1'b0, 1'b0, 59, 68);
    load_case(1'b1, 1'b1, 1'b0, 16'h0000, 1'b1, 1'b0, BUSPWR - 8, BUSPWR + 8);
    load_case(1'b1, 1'b0, 1'b1, 16'h0190, 1'b0, 1'b1, 399, 408);
    bus_reset_case();
    request_case();
    wrap_up();
  end
endmodule
